// ---- src/perf_monitor_pkg.sv ----
// Constants and types for the performance monitor configuration and control registers.
// How it works
// (RULE_01) Configuration counter-group field, bits 31 to 28, reads zero.
// (RULE_02) Configuration user-enable-supported bit 19 reads zero.
// (RULE_03) Configuration unsupported-feature bits 18 and 17 read zero.
// (RULE_04) Configuration cycle-prescale bit 15 reads zero.
// (RULE_05) Configuration cycle-counter-present bit 14 reads one.
// (RULE_06) Configuration counter-size field, bits 13 to 8, reads all ones.
// (RULE_07) Configuration counter-count field holds event counter count, six or twenty.
// (RULE_08) Never more than thirty-one event counters.
// (RULE_09) With long-counter bit set, overflow only on full 64-bit wrap.
// (RULE_10) Cycle-gating bit stops cycle counter while low-range counting is prohibited.
// (RULE_11) Events go on the export bus only while export-enable is one.
// (RULE_12) No events exported while counting is prohibited.
// (RULE_13) Overflow requests do not depend on export-enable.
// (RULE_14) Writing one to cycle-reset bit clears the cycle counter; nothing stored.
// (RULE_15) Writing one to event-reset bit clears all event counters, not cycle.
// (RULE_16) Global enable lets counters count per their counter-enable-set bit.
// (RULE_17) Event reset never touches captured snapshot copies.
// (RULE_18) Reserved control bits read zero, bit 6 reads one; writes ignored.
package perf_monitor_pkg;

    localparam int          ADDR_W            = 12;
    localparam int          DATA_W            = 32;
    localparam int          CNT_W             = 64;
    localparam int          LOW_CNT_W         = 32;
    localparam int          MAX_EVENT_CNT     = 31;
    localparam int          CYCLE_ENSET_BIT   = 31;

    localparam logic [11:0] CFG_OFFSET        = 12'hE00;
    localparam logic [11:0] CTRL_OFFSET       = 12'hE04;

    // Control register bit positions.
    localparam int          CTRL_E_BIT        = 0;
    localparam int          CTRL_P_BIT        = 1;
    localparam int          CTRL_C_BIT        = 2;
    localparam int          CTRL_X_BIT        = 4;
    localparam int          CTRL_GATE_BIT     = 5;
    localparam int          CTRL_RES1_BIT     = 6;
    localparam int          CTRL_LONG_BIT     = 7;

    // Configuration register field positions and fixed values.
    localparam int          CFG_GROUP_LSB     = 28;
    localparam int          CFG_USER_EN_BIT   = 19;
    localparam int          CFG_UNSUP18_BIT   = 18;
    localparam int          CFG_UNSUP17_BIT   = 17;
    localparam int          CFG_EXPORT_BIT    = 16;
    localparam int          CFG_PRESCALE_BIT  = 15;
    localparam int          CFG_CYCLE_BIT     = 14;
    localparam int          CFG_SIZE_LSB      = 8;
    localparam int          CFG_COUNT_LSB     = 0;
    localparam logic [3:0]  CFG_GROUP_VAL     = 4'h0;
    localparam logic [5:0]  CFG_SIZE_VAL      = 6'h3F;
    localparam logic [7:0]  CFG_COUNT_DEFAULT = 8'h06;
    localparam logic [7:0]  CFG_COUNT_ALT     = 8'h14;

    localparam logic [31:0] RDATA_RESET       = 32'h0000_0000;

    typedef struct packed {
        logic              sel;
        logic              wr;
        logic [11:0]       addr;
        logic [31:0]       wdata;
    } reg_req_type;

    typedef struct packed {
        logic long_cnt;
        logic cyc_gate;
        logic x;
        logic e;
    } ctrl_type;

    localparam ctrl_type    CTRL_RESET        = '{long_cnt: 1'b0, cyc_gate: 1'b0, x: 1'b0, e: 1'b0};

endpackage

// ---- src/perf_overflow_detect.sv ----
// Overflow detection for one event counter increment, 32-bit or 64-bit wrap.
`timescale 1ns/100ps
module perf_overflow_detect
    import perf_monitor_pkg::*;
(
    input  wire logic              increment,   // Counter increments this cycle.
    input  wire logic [CNT_W-1:0]  count_val,   // Counter value before the increment.
    input  wire logic              long_mode,   // Long-counter control bit.
    output      logic              wrap         // Increment wraps the selected width.
);

    logic full_wrap;
    logic low_wrap;

    assign full_wrap = &count_val;
    assign low_wrap  = &count_val[LOW_CNT_W-1:0];
    assign wrap      = increment & (long_mode ? full_wrap : low_wrap); // RULE_09

endmodule

// ---- src/perf_monitor_regs.sv ----
// Configuration and control registers of the performance monitor with counter control outputs.
`timescale 1ns/100ps
module perf_monitor_regs
    import perf_monitor_pkg::*;
#(
    parameter int unsigned NUM_EVENT_COUNTERS = 6
)
(
    input  wire logic                          clk_sys,          // Core clock, 100 MHz.
    input  wire logic                          rst_n,            // Synchronous reset, active low.
    input  wire reg_req_type                   reg_req,          // Debug view register request.
    output      logic [DATA_W-1:0]             reg_rdata_ff,     // Read data, valid with ack.
    output      logic                          reg_ack_ff,       // Request completed pulse.
    input  wire logic [DATA_W-1:0]             counter_enable_set, // Per-counter enables, bit 31 cycle.
    input  wire logic                          prohibit_low,     // Counting prohibited below limit.
    input  wire logic                          prohibit_any,     // Counting prohibited in this state.
    input  wire logic [NUM_EVENT_COUNTERS-1:0] event_in,         // Counted event pulses.
    input  wire logic [NUM_EVENT_COUNTERS-1:0] evt_increment,    // Event counter increments now.
    input  wire logic [NUM_EVENT_COUNTERS-1:0][CNT_W-1:0] evt_count_val, // Live counter values.
    output      logic [NUM_EVENT_COUNTERS-1:0] evt_count_en_ff,  // Event counter may count.
    output      logic                          cycle_count_en_ff, // Cycle counter may count.
    output      logic                          cycle_clear_ff,   // Clear cycle counter pulse.
    output      logic                          event_clear_ff,   // Clear live event counters pulse.
    output      logic [NUM_EVENT_COUNTERS-1:0] export_bus_ff,    // Event export bus.
    output      logic [NUM_EVENT_COUNTERS-1:0] overflow_ff       // Overflow requests.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode.

    localparam logic [7:0] COUNT_FIELD = 8'(NUM_EVENT_COUNTERS); // RULE_07 RULE_08

    logic                          hit_cfg;
    logic                          hit_ctrl;
    logic                          rd_req;
    logic                          wr_ctrl;
    logic [DATA_W-1:0]             cfg_value;
    logic [DATA_W-1:0]             ctrl_value;
    logic [DATA_W-1:0]             nxt_rdata;
    ctrl_type                      ctrl_ff;
    ctrl_type                      nxt_ctrl;
    logic                          nxt_cycle_clear;
    logic                          nxt_event_clear;
    logic                          cycle_gated;
    logic                          export_open;
    logic [NUM_EVENT_COUNTERS-1:0] nxt_evt_en;
    logic [NUM_EVENT_COUNTERS-1:0] nxt_export;
    logic [NUM_EVENT_COUNTERS-1:0] wrap_vec;

    assign hit_cfg  = reg_req.addr == CFG_OFFSET;
    assign hit_ctrl = reg_req.addr == CTRL_OFFSET;
    assign rd_req   = reg_req.sel & ~reg_req.wr;
    assign wr_ctrl  = reg_req.sel & reg_req.wr & hit_ctrl;

    ////////////////////////////////////////////////////////////////////////////////
    // Read values. The configuration register is wholly constant.

    always_comb begin
        cfg_value                               = '0;
        cfg_value[CFG_GROUP_LSB +: 4]           = CFG_GROUP_VAL; // RULE_01
        cfg_value[CFG_USER_EN_BIT]              = 1'b0;          // RULE_02
        cfg_value[CFG_UNSUP18_BIT]              = 1'b0;          // RULE_03
        cfg_value[CFG_UNSUP17_BIT]              = 1'b0;          // RULE_03
        cfg_value[CFG_EXPORT_BIT]               = 1'b1;
        cfg_value[CFG_PRESCALE_BIT]             = 1'b0;          // RULE_04
        cfg_value[CFG_CYCLE_BIT]                = 1'b1;          // RULE_05
        cfg_value[CFG_SIZE_LSB +: 6]            = CFG_SIZE_VAL;  // RULE_06
        cfg_value[CFG_COUNT_LSB +: 8]           = COUNT_FIELD;   // RULE_07
    end

    // Reset bits are actions only and read back zero.
    always_comb begin
        ctrl_value                  = '0;                         // RULE_18
        ctrl_value[CTRL_RES1_BIT]   = 1'b1;                       // RULE_18
        ctrl_value[CTRL_LONG_BIT]   = ctrl_ff.long_cnt;
        ctrl_value[CTRL_GATE_BIT]   = ctrl_ff.cyc_gate;
        ctrl_value[CTRL_X_BIT]      = ctrl_ff.x;
        ctrl_value[CTRL_E_BIT]      = ctrl_ff.e;
    end

    assign nxt_rdata = ~rd_req  ? reg_rdata_ff :
                       hit_cfg  ? cfg_value :
                       hit_ctrl ? ctrl_value : RDATA_RESET;

    ////////////////////////////////////////////////////////////////////////////////
    // Control writes. Only the four stored fields take the write data.

    assign nxt_ctrl.long_cnt = wr_ctrl ? reg_req.wdata[CTRL_LONG_BIT] : ctrl_ff.long_cnt;
    assign nxt_ctrl.cyc_gate = wr_ctrl ? reg_req.wdata[CTRL_GATE_BIT] : ctrl_ff.cyc_gate;
    assign nxt_ctrl.x       = wr_ctrl ? reg_req.wdata[CTRL_X_BIT]  : ctrl_ff.x;
    assign nxt_ctrl.e       = wr_ctrl ? reg_req.wdata[CTRL_E_BIT]  : ctrl_ff.e;
    assign nxt_cycle_clear  = wr_ctrl & reg_req.wdata[CTRL_C_BIT]; // RULE_14
    // The clear goes to live counters only; snapshot copies are held elsewhere.
    assign nxt_event_clear  = wr_ctrl & reg_req.wdata[CTRL_P_BIT]; // RULE_15 RULE_17

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_ff        <= CTRL_RESET;
            reg_rdata_ff   <= RDATA_RESET;
            reg_ack_ff     <= 1'b0;
            cycle_clear_ff <= 1'b0;
            event_clear_ff <= 1'b0;
        end else begin
            ctrl_ff        <= nxt_ctrl;
            reg_rdata_ff   <= nxt_rdata;
            reg_ack_ff     <= reg_req.sel;
            cycle_clear_ff <= nxt_cycle_clear;
            event_clear_ff <= nxt_event_clear;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counting enables, export and overflow.

    assign cycle_gated = ctrl_ff.cyc_gate & prohibit_low;         // RULE_10
    assign export_open = ctrl_ff.x & ~prohibit_any;               // RULE_11 RULE_12
    assign nxt_evt_en  = {NUM_EVENT_COUNTERS{ctrl_ff.e}}
                         & counter_enable_set[NUM_EVENT_COUNTERS-1:0]; // RULE_16
    assign nxt_export  = {NUM_EVENT_COUNTERS{export_open}} & event_in;

    for (genvar i = 0; i < NUM_EVENT_COUNTERS; i++) begin : g_ovf
        perf_overflow_detect u_ovf (
            .increment (evt_increment[i]),
            .count_val (evt_count_val[i]),
            .long_mode (ctrl_ff.long_cnt),
            .wrap      (wrap_vec[i])
        );
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            evt_count_en_ff   <= '0;
            cycle_count_en_ff <= 1'b0;
            export_bus_ff     <= '0;
            overflow_ff       <= '0;
        end else begin
            evt_count_en_ff   <= nxt_evt_en;                      // RULE_16
            cycle_count_en_ff <= ctrl_ff.e & counter_enable_set[CYCLE_ENSET_BIT] & ~cycle_gated; // RULE_10
            export_bus_ff     <= nxt_export;                      // RULE_11
            overflow_ff       <= wrap_vec;                        // RULE_13
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence cfg_read_s;
        reg_req.sel && !reg_req.wr && hit_cfg;
    endsequence

    sequence ctrl_read_s;
        reg_req.sel && !reg_req.wr && hit_ctrl;
    endsequence

    cfg_group_a: assert property (cfg_read_s |=> reg_ack_ff && reg_rdata_ff[31:28] == 4'h0) // RULE_01
        else $error("counter group field not zero");

    cfg_user_a: assert property (cfg_read_s |=> !reg_rdata_ff[CFG_USER_EN_BIT]) // RULE_02
        else $error("user enable supported bit not zero");

    cfg_unsup_a: assert property (cfg_read_s |=> reg_rdata_ff[18:17] == 2'b00) // RULE_03
        else $error("unsupported feature bits not zero");

    cfg_prescale_a: assert property (cfg_read_s |=> !reg_rdata_ff[CFG_PRESCALE_BIT]) // RULE_04
        else $error("cycle prescale bit not zero");

    cfg_cycle_a: assert property (cfg_read_s |=> reg_rdata_ff[CFG_CYCLE_BIT]) // RULE_05
        else $error("cycle counter present bit not one");

    cfg_size_a: assert property (cfg_read_s |=> reg_rdata_ff[13:8] == 6'h3F) // RULE_06
        else $error("counter size field not all ones");

    cfg_count_a: assert property (cfg_read_s |=> reg_rdata_ff[7:0] == COUNT_FIELD // RULE_07
                                  && (COUNT_FIELD == CFG_COUNT_DEFAULT || COUNT_FIELD == CFG_COUNT_ALT))
        else $error("counter count field wrong");

    count_max_a: assert property (cfg_read_s |=> reg_rdata_ff[7:0] <= 8'(MAX_EVENT_CNT)) // RULE_08
        else $error("counter count above thirty one");

    long_wrap_a: assert property (ctrl_ff.long_cnt && evt_increment[0] // RULE_09
                                  && evt_count_val[0][31:0] == 32'hFFFF_FFFF
                                  && evt_count_val[0][63:32] != 32'hFFFF_FFFF |=> !overflow_ff[0])
        else $error("overflow on 32-bit wrap in long mode");

    full_wrap_a: assert property (evt_increment[0] && &evt_count_val[0] |=> overflow_ff[0]) // RULE_09
        else $error("missed 64-bit wrap overflow");

    cycle_gate_a: assert property (ctrl_ff.cyc_gate && prohibit_low |=> !cycle_count_en_ff) // RULE_10
        else $error("cycle counter runs while gated");

    cycle_free_a: assert property (ctrl_ff.e && !ctrl_ff.cyc_gate // RULE_10
                                   && counter_enable_set[CYCLE_ENSET_BIT] |=> cycle_count_en_ff)
        else $error("cycle counter stopped without gating");

    export_off_a: assert property (!ctrl_ff.x |=> export_bus_ff == '0) // RULE_11
        else $error("events exported while export disabled");

    export_on_a: assert property (ctrl_ff.x && !prohibit_any |=> export_bus_ff == $past(event_in)) // RULE_11
        else $error("export bus does not follow events");

    export_proh_a: assert property (prohibit_any |=> export_bus_ff == '0) // RULE_12
        else $error("events exported while prohibited");

    ovf_indep_a: assert property (!ctrl_ff.x && !ctrl_ff.long_cnt && evt_increment[0] // RULE_13
                                  && evt_count_val[0][31:0] == 32'hFFFF_FFFF |=> overflow_ff[0])
        else $error("overflow suppressed by export bit");

    cycle_clr_a: assert property (wr_ctrl && reg_req.wdata[CTRL_C_BIT] // RULE_14
                                  |=> cycle_clear_ff ##1 !cycle_clear_ff || $past(nxt_cycle_clear))
        else $error("cycle clear pulse wrong");

    cycle_nostore_a: assert property (ctrl_read_s |=> !reg_rdata_ff[CTRL_C_BIT] && !reg_rdata_ff[CTRL_P_BIT]) // RULE_14
        else $error("reset bits read back nonzero");

    event_clr_a: assert property (wr_ctrl && reg_req.wdata[CTRL_P_BIT] && !reg_req.wdata[CTRL_C_BIT] // RULE_15
                                  |=> event_clear_ff && !cycle_clear_ff)
        else $error("event clear wrong or touched cycle counter");

    event_only_a: assert property (event_clear_ff |-> $past(wr_ctrl)) // RULE_17
        else $error("event clear without a control write");

    enable_off_a: assert property (!ctrl_ff.e |=> evt_count_en_ff == '0 && !cycle_count_en_ff) // RULE_16
        else $error("counters enabled while global enable clear");

    enable_on_a: assert property (ctrl_ff.e |=> evt_count_en_ff // RULE_16
                                  == $past(counter_enable_set[NUM_EVENT_COUNTERS-1:0]))
        else $error("event enables do not follow enable set");

    ctrl_rsvd_a: assert property (ctrl_read_s |=> reg_rdata_ff[31:8] == 24'h00_0000 // RULE_18
                                  && reg_rdata_ff[CTRL_RES1_BIT] && !reg_rdata_ff[3])
        else $error("reserved control bits wrong");

    // A control write followed at once by a read of the control register.
    sequence ctrl_wr_rd_s;
        wr_ctrl ##1 ctrl_read_s;
    endsequence

    ctrl_store_a: assert property (ctrl_wr_rd_s |=> reg_rdata_ff[CTRL_LONG_BIT] // RULE_09
                                   == $past(reg_req.wdata[CTRL_LONG_BIT], 2))
        else $error("long counter bit not stored");

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the stored control fields, the action bits and the widest counter index.

    gate_store_a: assert property (ctrl_wr_rd_s |=> reg_rdata_ff[CTRL_GATE_BIT] // RULE_10
                                   == $past(reg_req.wdata[CTRL_GATE_BIT], 2))
        else $error("cycle gating bit not stored");

    export_store_a: assert property (ctrl_wr_rd_s |=> reg_rdata_ff[CTRL_X_BIT] // RULE_11
                                     == $past(reg_req.wdata[CTRL_X_BIT], 2))
        else $error("export enable bit not stored");

    enable_store_a: assert property (ctrl_wr_rd_s |=> reg_rdata_ff[CTRL_E_BIT] // RULE_16
                                     == $past(reg_req.wdata[CTRL_E_BIT], 2))
        else $error("global enable bit not stored");

    rsvd_write_a: assert property (ctrl_wr_rd_s |=> reg_rdata_ff[31:8] == 24'h00_0000 // RULE_18
                                   && reg_rdata_ff[CTRL_RES1_BIT] && !reg_rdata_ff[3])
        else $error("reserved control bits took a write");

    cycle_idle_a: assert property (!(wr_ctrl && reg_req.wdata[CTRL_C_BIT]) |=> !cycle_clear_ff) // RULE_14
        else $error("cycle clear without a write of one");

    event_idle_a: assert property (!(wr_ctrl && reg_req.wdata[CTRL_P_BIT]) |=> !event_clear_ff) // RULE_15
        else $error("event clear without a write of one");

    cycle_only_a: assert property (wr_ctrl && reg_req.wdata[CTRL_C_BIT] && !reg_req.wdata[CTRL_P_BIT] // RULE_15
                                   |=> cycle_clear_ff && !event_clear_ff)
        else $error("cycle clear also cleared event counters");

    no_incr_a: assert property (evt_increment == '0 |=> overflow_ff == '0) // RULE_09
        else $error("overflow without an increment");

    top_wrap_a: assert property (evt_increment[NUM_EVENT_COUNTERS-1] // RULE_09
                                 && &evt_count_val[NUM_EVENT_COUNTERS-1] |=> overflow_ff[NUM_EVENT_COUNTERS-1])
        else $error("missed 64-bit wrap on last counter");

    ovf_export_a: assert property (ctrl_ff.x && evt_increment[0] && &evt_count_val[0] |=> overflow_ff[0]) // RULE_13
        else $error("overflow suppressed while exporting");

    cycle_off_a: assert property (!counter_enable_set[CYCLE_ENSET_BIT] |=> !cycle_count_en_ff) // RULE_16
        else $error("cycle counter runs without its enable");

    top_enable_a: assert property (ctrl_ff.e && counter_enable_set[NUM_EVENT_COUNTERS-1] // RULE_16
                                   |=> evt_count_en_ff[NUM_EVENT_COUNTERS-1])
        else $error("last event counter not enabled");

endmodule

// ---- verification/tb_top.sv ----
// Self-checking testbench for the performance monitor configuration and control registers.
`timescale 1ns/100ps
module tb_top;
    import perf_monitor_pkg::*;

    localparam int NEV = 6;

    logic                     clk_sys;
    logic                     rst_n;
    reg_req_type              reg_req;
    logic [DATA_W-1:0]        reg_rdata_ff;
    logic                     reg_ack_ff;
    logic [DATA_W-1:0]        counter_enable_set;
    logic                     prohibit_low;
    logic                     prohibit_any;
    logic [NEV-1:0]           event_in;
    logic [NEV-1:0]           evt_increment;
    logic [NEV-1:0][CNT_W-1:0] evt_count_val;
    logic [NEV-1:0]           evt_count_en_ff;
    logic                     cycle_count_en_ff;
    logic                     cycle_clear_ff;
    logic                     event_clear_ff;
    logic [NEV-1:0]           export_bus_ff;
    logic [NEV-1:0]           overflow_ff;
    logic [31:0]              seed;
    int                       n_mismatch;
    int                       n_tests;

    perf_monitor_regs #(.NUM_EVENT_COUNTERS(NEV)) dut_u (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .reg_req            (reg_req),
        .reg_rdata_ff       (reg_rdata_ff),
        .reg_ack_ff         (reg_ack_ff),
        .counter_enable_set (counter_enable_set),
        .prohibit_low       (prohibit_low),
        .prohibit_any       (prohibit_any),
        .event_in           (event_in),
        .evt_increment      (evt_increment),
        .evt_count_val      (evt_count_val),
        .evt_count_en_ff    (evt_count_en_ff),
        .cycle_count_en_ff  (cycle_count_en_ff),
        .cycle_clear_ff     (cycle_clear_ff),
        .event_clear_ff     (event_clear_ff),
        .export_bus_ff      (export_bus_ff),
        .overflow_ff        (overflow_ff)
    );

    always #5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Overflow is judged on the full 64 bits in long mode, on the low word otherwise.
    function automatic logic [NEV-1:0] exp_ovf(input logic [NEV-1:0] inc, input logic long_md);
        logic [NEV-1:0] r;
        for (int i = 0; i < NEV; i++) begin
            r[i] = inc[i] & (long_md ? (&evt_count_val[i]) : (&evt_count_val[i][31:0]));
        end
        return r;
    endfunction

    function automatic logic exp_cyc(input logic [31:0] w, input logic [31:0] en, input logic pl);
        return w[0] & en[31] & ~(w[5] & pl);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Leaves the request raised so that back-to-back accesses never assign sel twice at one time.
    task automatic reg_op(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        reg_req = '{sel: 1'h1, wr: wr, addr: a, wdata: d};
        @(posedge clk_sys);
        #1;
        chk({31'h0, reg_ack_ff}, 32'h1);
        q = reg_rdata_ff;
        chk({31'h0, cycle_clear_ff}, {31'h0, wr & (a == 12'hE04) & d[2]});
        chk({31'h0, event_clear_ff}, {31'h0, wr & (a == 12'hE04) & d[1]});
    endtask

    task automatic close_out();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic [31:0] w;
        logic [31:0] cfg_exp;
        logic [1:0]  pick;
        clk_sys = 1'h0;
        rst_n = 1'h0;
        seed = 32'hDD33;
        n_mismatch = 0;
        n_tests = 0;
        reg_req = '0;
        counter_enable_set = '0;
        prohibit_low = 1'h0;
        prohibit_any = 1'h0;
        event_in = '0;
        evt_increment = '0;
        evt_count_val = '0;
        cfg_exp = {4'h0, 8'h00, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 6'h3F, 8'(NEV)};
        repeat (16) @(posedge clk_sys);
        #1;
        chk({reg_ack_ff, cycle_clear_ff, event_clear_ff, cycle_count_en_ff}, 32'h0);
        chk({evt_count_en_ff, export_bus_ff, overflow_ff}, 32'h0);
        rst_n = 1'h1;
        @(posedge clk_sys);
        #1;
        reg_op(1'h0, 12'hE00, 32'h0, q);
        chk(q, cfg_exp);
        reg_op(1'h0, 12'hE04, 32'h0, q);
        chk(q, 32'h0000_0040);
        reg_op(1'h1, 12'hE00, 32'hFFFF_FFFF, q);
        reg_op(1'h0, 12'hE00, 32'h0, q);
        chk(q, cfg_exp);
        reg_op(1'h1, 12'hE08, 32'hFFFF_FFFF, q);
        reg_op(1'h0, 12'hE08, 32'h0, q);
        chk(q, 32'h0);
        reg_op(1'h1, 12'hE04, 32'hFFFF_FFF9, q);
        reg_op(1'h0, 12'hE04, 32'h0, q);
        chk(q, 32'h0000_00F1);
        reg_req.sel = 1'h0;
        @(posedge clk_sys);
        #1;
        chk({31'h0, reg_ack_ff}, 32'h0);
        for (int k = 0; k < 60; k++) begin
            w = (k == 0) ? 32'hFFFF_FFFF : ((k == 1) ? 32'h0 : rnd());
            reg_op(1'h1, 12'hE04, w, q);
            reg_req.sel = 1'h0;
            counter_enable_set = rnd();
            w[31] = rnd() > 32'h8000_0000;
            prohibit_low = rnd() > 32'h8000_0000;
            prohibit_any = rnd() > 32'hA000_0000;
            event_in = NEV'(rnd());
            evt_increment = NEV'(rnd());
            for (int i = 0; i < NEV; i++) begin
                pick = 2'(rnd());
                evt_count_val[i] = (pick == 2'h0) ? 64'hFFFF_FFFF_FFFF_FFFF :
                                   (pick == 2'h1) ? {rnd(), 32'hFFFF_FFFF} : {rnd(), rnd()};
            end
            @(posedge clk_sys);
            #1;
            chk({reg_ack_ff, cycle_clear_ff, event_clear_ff}, 32'h0);
            chk(32'(evt_count_en_ff), w[0] ? 32'(counter_enable_set[NEV-1:0]) : 32'h0);
            chk({31'h0, cycle_count_en_ff}, {31'h0, exp_cyc(w, counter_enable_set, prohibit_low)});
            chk(32'(export_bus_ff), (w[4] & ~prohibit_any) ? 32'(event_in) : 32'h0);
            chk(32'(overflow_ff), 32'(exp_ovf(evt_increment, w[7])));
            reg_op(1'h0, 12'hE04, 32'h0, q);
            chk(q, (w & 32'h0000_00B1) | 32'h0000_0040);
            reg_req.sel = 1'h0;
            @(posedge clk_sys);
            #1;
        end
        rst_n = 1'h0;
        @(posedge clk_sys);
        #1;
        chk({evt_count_en_ff, export_bus_ff, overflow_ff, cycle_count_en_ff}, 32'h0);
        rst_n = 1'h1;
        @(posedge clk_sys);
        #1;
        reg_op(1'h0, 12'hE04, 32'h0, q);
        chk(q, 32'h0000_0040);
        close_out();
    end
endmodule
